// ===== hw/pdl_bank.v
`include "pdl_consts.vh"

module pdl_bank
#(
  parameter DELAY_EXP_BASE = `PDL_DELAY_EXP_BASE,
  parameter CNT_W          = 27
)
(
  // Clock and reset.
  input  wire        CORE_CLK,
  input  wire        RST_N,
  // Register port of the management interface.
  input  wire [7:0]  REG_ADDR,
  input  wire        REG_WR,
  input  wire [7:0]  REG_WDATA,
  input  wire        REG_RD,
  output reg  [7:0]  REG_RDATA,
  // Loop status inputs.
  input  wire        IN_CLK_PRESENT,
  input  wire [15:0] FREQ_ERR,
  input  wire        FREQ_ERR_VALID,
  // Divider configuration.
  output reg  [4:0]  DIV2_INT_HI,
  output reg         DIV2_FORCE_INT,
  output reg  [31:0] DIV2_FRAC_NUM,
  output reg  [31:0] DIV2_FRAC_DEN,
  // Outputs and loop status.
  output reg  [5:0]  OUT_EN,
  output reg         WAKE_DONE,
  output wire        LOCK_LOSS
);

  localparam [2:0] ST_START = 3'b001;
  localparam [2:0] ST_WAIT  = 3'b010;
  localparam [2:0] ST_RUN   = 3'b100;
  localparam integer REF_LAST_I = `PDL_REF_DIV - 1;
  localparam [4:0]   REF_LAST   = REF_LAST_I[4:0];

  reg [5:0]  int_hi_ff;
  reg [31:0] num_ff;
  reg [31:0] den_ff;
  reg [7:0]  out_en_ff;
  reg [7:0]  ll1_ff;
  reg [7:0]  ll2_ff;
  reg [7:0]  rdata_ff;
  reg [7:0]  nxt_rdata;
  reg        clk_meta_ff;
  reg        clk_sync_ff;
  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg [4:0]  ref_cnt_ff;
  reg        ref_tick_ff;

  // Address match used by every write decode.
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Register writes. Reserved bits of 28h and 29h are stored as written.
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      int_hi_ff <= `PDL_RST_INT_HI;
      num_ff <= {4{`PDL_RST_BYTE}};
      den_ff <= {4{`PDL_RST_BYTE}};
      out_en_ff <= `PDL_RST_BYTE;
      ll1_ff <= `PDL_RST_BYTE;
      ll2_ff <= `PDL_RST_BYTE;
    end
    else if (REG_WR)
    begin
      if (hit(REG_ADDR, `PDL_OFS_DIV2_INT_HI))
        int_hi_ff <= REG_WDATA[5:0];
      if (hit(REG_ADDR, `PDL_OFS_FRAC_NUM_B1))
        num_ff[7:0] <= REG_WDATA;
      if (hit(REG_ADDR, `PDL_OFS_FRAC_NUM_B2))
        num_ff[15:8] <= REG_WDATA;
      if (hit(REG_ADDR, `PDL_OFS_FRAC_NUM_B3))
        num_ff[23:16] <= REG_WDATA;
      if (hit(REG_ADDR, `PDL_OFS_FRAC_NUM_B4))
        num_ff[31:24] <= REG_WDATA;
      if (hit(REG_ADDR, `PDL_OFS_FRAC_DEN_B1))
        den_ff[7:0] <= REG_WDATA;
      if (hit(REG_ADDR, `PDL_OFS_FRAC_DEN_B2))
        den_ff[15:8] <= REG_WDATA;
      if (hit(REG_ADDR, `PDL_OFS_FRAC_DEN_B3))
        den_ff[23:16] <= REG_WDATA;
      if (hit(REG_ADDR, `PDL_OFS_FRAC_DEN_B4))
        den_ff[31:24] <= REG_WDATA;
      if (hit(REG_ADDR, `PDL_OFS_OUT_EN))
        out_en_ff <= REG_WDATA;
      if (hit(REG_ADDR, `PDL_OFS_LL_CTRL1))
        ll1_ff <= REG_WDATA;
      if (hit(REG_ADDR, `PDL_OFS_LL_CTRL2))
        ll2_ff <= REG_WDATA;
    end
  end

  // Read mux; unmapped offsets read as zero.
  always @*
  begin
    case (REG_ADDR)
      `PDL_OFS_DIV2_INT_HI: nxt_rdata = {2'b00, int_hi_ff};
      `PDL_OFS_FRAC_NUM_B1: nxt_rdata = num_ff[7:0];
      `PDL_OFS_FRAC_NUM_B2: nxt_rdata = num_ff[15:8];
      `PDL_OFS_FRAC_NUM_B3: nxt_rdata = num_ff[23:16];
      `PDL_OFS_FRAC_NUM_B4: nxt_rdata = num_ff[31:24];
      `PDL_OFS_FRAC_DEN_B1: nxt_rdata = den_ff[7:0];
      `PDL_OFS_FRAC_DEN_B2: nxt_rdata = den_ff[15:8];
      `PDL_OFS_FRAC_DEN_B3: nxt_rdata = den_ff[23:16];
      `PDL_OFS_FRAC_DEN_B4: nxt_rdata = den_ff[31:24];
      `PDL_OFS_OUT_EN:      nxt_rdata = out_en_ff;
      `PDL_OFS_LL_CTRL1:    nxt_rdata = ll1_ff;
      `PDL_OFS_LL_CTRL2:    nxt_rdata = ll2_ff;
      default:              nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_ff <= 8'h00;
    else if (REG_RD)
      rdata_ff <= nxt_rdata;
  end

  // Configuration outputs registered once more so they leave from flops.
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REG_RDATA <= 8'h00;
      DIV2_INT_HI <= 5'h00;
      DIV2_FORCE_INT <= 1'b0;
      DIV2_FRAC_NUM <= 32'h00000000;
      DIV2_FRAC_DEN <= 32'h00000000;
      OUT_EN <= 6'h00;
    end
    else
    begin
      REG_RDATA <= rdata_ff;
      DIV2_INT_HI <= int_hi_ff[`PDL_INT_HI_MSB:0];
      DIV2_FORCE_INT <= int_hi_ff[`PDL_BIT_FORCE_INT];
      DIV2_FRAC_NUM <= num_ff;
      DIV2_FRAC_DEN <= den_ff;
      OUT_EN <= out_en_ff[`PDL_OUT_EN_MSB:0];
    end
  end

  // The input-clock detector is asynchronous to this clock.
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      clk_meta_ff <= 1'b0;
      clk_sync_ff <= 1'b0;
    end
    else
    begin
      clk_meta_ff <= IN_CLK_PRESENT;
      clk_sync_ff <= clk_meta_ff;
    end
  end

  // Wake-up sequence: leaves reset, optionally waits for the input clock.
  // It lingers in the start state until the first reference tick, so that
  // software has a window to request the wait before the sequence moves on.
  always @*
  begin
    case (state_ff)
      ST_START:
        if (!ref_tick_ff)
          nxt_state = ST_START;
        else if (ll1_ff[`PDL_BIT_WAIT_CLK] && !clk_sync_ff)
          nxt_state = ST_WAIT;
        else
          nxt_state = ST_RUN;
      ST_WAIT:
        if (clk_sync_ff || !ll1_ff[`PDL_BIT_WAIT_CLK])
          nxt_state = ST_RUN;
        else
          nxt_state = ST_WAIT;
      ST_RUN:
        nxt_state = ST_RUN;
      default:
        nxt_state = ST_START;
    endcase
  end

  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_ff <= ST_START;
      WAKE_DONE <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      WAKE_DONE <= (nxt_state == ST_RUN);
    end
  end

  // 4 MHz reference enable from the core clock.
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ref_cnt_ff <= 5'h00;
      ref_tick_ff <= 1'b0;
    end
    else
    begin
      ref_tick_ff <= (ref_cnt_ff == REF_LAST);
      if (ref_cnt_ff == REF_LAST)
        ref_cnt_ff <= 5'h00;
      else
        ref_cnt_ff <= ref_cnt_ff + 5'h01;
    end
  end

  pdl_lock_mon
  #(
    .DELAY_EXP_BASE (DELAY_EXP_BASE),
    .CNT_W          (CNT_W)
  )
  u_lock_mon
  (
    .CORE_CLK       (CORE_CLK),
    .RST_N          (RST_N),
    .ref_tick       (ref_tick_ff),
    .freq_err       (FREQ_ERR),
    .freq_err_valid (FREQ_ERR_VALID),
    .set_code       (ll2_ff[`PDL_SET_MSB:`PDL_SET_LSB]),
    .clr_code       ({ll1_ff[`PDL_BIT_CLR_HI],
                      ll2_ff[`PDL_BIT_CLR_LO]}),
    .delay_code     (ll1_ff[`PDL_DELAY_MSB:`PDL_DELAY_LSB]),
    .lock_loss_ff   (LOCK_LOSS)
  );

endmodule

// ===== inc/pdl_consts.vh
`ifndef PDL_CONSTS_VH
`define PDL_CONSTS_VH

// Register offsets of the loop's divider and lock-loss bank.
`define PDL_OFS_DIV2_INT_HI    8'h1F
`define PDL_OFS_FRAC_NUM_B1    8'h20
`define PDL_OFS_FRAC_NUM_B2    8'h21
`define PDL_OFS_FRAC_NUM_B3    8'h22
`define PDL_OFS_FRAC_NUM_B4    8'h23
`define PDL_OFS_FRAC_DEN_B1    8'h24
`define PDL_OFS_FRAC_DEN_B2    8'h25
`define PDL_OFS_FRAC_DEN_B3    8'h26
`define PDL_OFS_FRAC_DEN_B4    8'h27
`define PDL_OFS_OUT_EN         8'h28
`define PDL_OFS_LL_CTRL1       8'h29
`define PDL_OFS_LL_CTRL2       8'h2A

// Field positions.
`define PDL_BIT_FORCE_INT      5
`define PDL_INT_HI_MSB         4
`define PDL_OUT_EN_MSB         5
`define PDL_BIT_WAIT_CLK       5
`define PDL_DELAY_MSB          3
`define PDL_DELAY_LSB          1
`define PDL_BIT_CLR_HI         0
`define PDL_BIT_CLR_LO         0
`define PDL_SET_MSB            7
`define PDL_SET_LSB            4

// Reset values.
`define PDL_RST_BYTE           8'h00
`define PDL_RST_INT_HI         6'h00

// Timing.
`define PDL_CLK_HZ             100000000
`define PDL_REF_HZ             4000000
`define PDL_REF_DIV            (`PDL_CLK_HZ / `PDL_REF_HZ)
`define PDL_DELAY_EXP_BASE     26

// Thresholds in units of 0.1 ppm.
`define PDL_THR_0P2            16'h0002
`define PDL_THR_0P4            16'h0004
`define PDL_THR_2              16'h0014
`define PDL_THR_4              16'h0028
`define PDL_THR_20             16'h00C8
`define PDL_THR_40             16'h0190
`define PDL_THR_200            16'h07D0
`define PDL_THR_400            16'h0FA0
`define PDL_THR_2000           16'h4E20
`define PDL_THR_4000           16'h9C40

`endif

// ===== hw/pdl_lock_mon.v
`include "pdl_consts.vh"

module pdl_lock_mon
#(
  parameter DELAY_EXP_BASE = `PDL_DELAY_EXP_BASE,
  parameter CNT_W          = 27
)
(
  // Clock and reset.
  input  wire              CORE_CLK,
  input  wire              RST_N,
  // Timing and measurement.
  input  wire              ref_tick,
  input  wire [15:0]       freq_err,
  input  wire              freq_err_valid,
  // Configuration.
  input  wire [3:0]        set_code,
  input  wire [1:0]        clr_code,
  input  wire [2:0]        delay_code,
  // Status.
  output reg               lock_loss_ff
);

  reg [CNT_W-1:0] cnt_ff;
  reg             below_ff;
  reg [CNT_W-1:0] target;
  reg [15:0]      set_thr;
  reg [15:0]      clr_thr;
  reg             nxt_lock_loss;
  reg             nxt_below;
  reg [CNT_W-1:0] nxt_cnt;
  integer         exp_i;

  function [15:0] set_decode;
    input [3:0] code;
    begin
      case (code)
        4'h0:    set_decode = `PDL_THR_0P2;
        4'h1:    set_decode = `PDL_THR_0P4;
        4'h2:    set_decode = `PDL_THR_2;
        4'h3:    set_decode = `PDL_THR_4;
        4'h4:    set_decode = `PDL_THR_20;
        4'h5:    set_decode = `PDL_THR_40;
        4'h6:    set_decode = `PDL_THR_200;
        4'h7:    set_decode = `PDL_THR_400;
        4'h8:    set_decode = `PDL_THR_2000;
        4'h9:    set_decode = `PDL_THR_4000;
        default: set_decode = `PDL_THR_0P2;
      endcase
    end
  endfunction

  function [15:0] clr_decode;
    input [1:0] code;
    begin
      case (code)
        2'h0:    clr_decode = `PDL_THR_0P2;
        2'h1:    clr_decode = `PDL_THR_0P4;
        2'h2:    clr_decode = `PDL_THR_2;
        default: clr_decode = `PDL_THR_200;
      endcase
    end
  endfunction

  always @*
  begin
    exp_i = 0;
    set_thr = set_decode(set_code);
    clr_thr = clr_decode(clr_code);
    // Short simulation bases would go negative for large codes; clamp.
    exp_i = DELAY_EXP_BASE - 2 * delay_code;
    if (exp_i < 0)
      exp_i = 0;
    target = {{(CNT_W-1){1'b0}}, 1'b1} << exp_i;
    nxt_lock_loss = lock_loss_ff;
    nxt_below = below_ff;
    nxt_cnt = cnt_ff;
    if (lock_loss_ff && below_ff && ref_tick)
    begin
      if (cnt_ff == target - {{(CNT_W-1){1'b0}}, 1'b1})
      begin
        nxt_lock_loss = 1'b0;
        nxt_below = 1'b0;
        nxt_cnt = {CNT_W{1'b0}};
      end
      else
        nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    // A fresh sample at or above the clear threshold zeroes the count, so an excursion restarts it.
    if (freq_err_valid)
    begin
      if (freq_err > set_thr)
      begin
        nxt_lock_loss = 1'b1;
        nxt_below = 1'b0;
        nxt_cnt = {CNT_W{1'b0}};
      end
      else if (freq_err < clr_thr)
        nxt_below = 1'b1;
      else
      begin
        nxt_below = 1'b0;
        nxt_cnt = {CNT_W{1'b0}};
      end
    end
  end

  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      lock_loss_ff <= 1'b1;
      below_ff <= 1'b0;
      cnt_ff <= {CNT_W{1'b0}};
    end
    else
    begin
      lock_loss_ff <= nxt_lock_loss;
      below_ff <= nxt_below;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// ===== sim/pdl_bank_assertions.sv
module pdl_bank_assertions (
  // Clock and reset.
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  // Register port.
  input wire logic [7:0]  REG_ADDR,
  input wire logic        REG_WR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  // Loop status.
  input wire logic [15:0] FREQ_ERR,
  input wire logic        FREQ_ERR_VALID,
  // Configuration and status outputs.
  input wire logic [4:0]  DIV2_INT_HI,
  input wire logic        DIV2_FORCE_INT,
  input wire logic [31:0] DIV2_FRAC_NUM,
  input wire logic [31:0] DIV2_FRAC_DEN,
  input wire logic [5:0]  OUT_EN,
  input wire logic        WAKE_DONE,
  input wire logic        LOCK_LOSS
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_wr(logic [7:0] a);
    REG_WR && REG_ADDR == a;
  endsequence

  sequence s_rd_unmapped;
    REG_RD && (REG_ADDR < 8'h1F || REG_ADDR > 8'h2A);
  endsequence

  AST_INT_HI: assert property (
    s_wr(8'h1F) |-> ##2 DIV2_INT_HI == $past(REG_WDATA[4:0], 2))
    else $error("upper integer bits not taken from write");
  AST_FORCE_INT: assert property (
    s_wr(8'h1F) |-> ##2 DIV2_FORCE_INT == $past(REG_WDATA[5], 2))
    else $error("integer force bit not taken from write");
  AST_NUM_TOP: assert property (
    s_wr(8'h23) |-> ##2 DIV2_FRAC_NUM[31:24] == $past(REG_WDATA, 2))
    else $error("numerator top byte wrong");
  AST_DEN_LOW: assert property (
    s_wr(8'h24) |-> ##2 DIV2_FRAC_DEN[7:0] == $past(REG_WDATA, 2))
    else $error("denominator low byte wrong");
  AST_OUT_EN: assert property (
    s_wr(8'h28) |-> ##2 OUT_EN == $past(REG_WDATA[5:0], 2))
    else $error("output enables not taken from write");
  AST_RSV_TOP: assert property (
    REG_RD && REG_ADDR == 8'h1F |-> ##2 REG_RDATA[7:6] == 2'b00)
    else $error("upper bits of divider register read nonzero");
  AST_RD_NONE: assert property (
    s_rd_unmapped |-> ##2 REG_RDATA == 8'h00)
    else $error("unmapped read returned data");
  AST_LL_SET: assert property (
    FREQ_ERR_VALID && FREQ_ERR == 16'hFFFF |=> LOCK_LOSS)
    else $error("lock loss not raised on large error");
  AST_WAKE_KEEP: assert property (
    WAKE_DONE |=> WAKE_DONE)
    else $error("wake-up done dropped");
endmodule

bind pdl_bank pdl_bank_assertions u_chk (
  .CORE_CLK(CORE_CLK),
  .RST_N(RST_N),
  .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA),
  .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA),
  .FREQ_ERR(FREQ_ERR),
  .FREQ_ERR_VALID(FREQ_ERR_VALID),
  .DIV2_INT_HI(DIV2_INT_HI),
  .DIV2_FORCE_INT(DIV2_FORCE_INT),
  .DIV2_FRAC_NUM(DIV2_FRAC_NUM),
  .DIV2_FRAC_DEN(DIV2_FRAC_DEN),
  .OUT_EN(OUT_EN),
  .WAKE_DONE(WAKE_DONE),
  .LOCK_LOSS(LOCK_LOSS)
);

// ===== sim/pdl_bank_tb.sv
module pdl_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Short release delay exponent keeps the run brief.
  localparam int BASE = 6;

  logic        core_clk       = 1'b0;
  logic        rst_n          = 1'b0;
  logic [7:0]  reg_addr       = 8'h00;
  logic        reg_wr         = 1'b0;
  logic [7:0]  reg_wdata      = 8'h00;
  logic        reg_rd         = 1'b0;
  logic        in_clk_present = 1'b0;
  logic [15:0] freq_err       = 16'h0000;
  logic        freq_err_valid = 1'b0;
  wire  [7:0]  reg_rdata;
  wire  [4:0]  div2_int_hi;
  wire         div2_force_int;
  wire  [31:0] div2_frac_num;
  wire  [31:0] div2_frac_den;
  wire  [5:0]  out_en;
  wire         wake_done;
  wire         lock_loss;
  int          miscompares    = 0;
  int          checks_done    = 0;
  int          n;
  logic [15:0] set_thr [10]   = '{16'h0002, 16'h0004, 16'h0014, 16'h0028,
    16'h00C8, 16'h0190, 16'h07D0, 16'h0FA0, 16'h4E20, 16'h9C40};
  logic [15:0] clr_thr [4]    = '{16'h0002, 16'h0004, 16'h0014, 16'h07D0};

  always #5 core_clk = ~core_clk;

  pdl_bank #(.DELAY_EXP_BASE(BASE)) dut_u (
    .CORE_CLK(core_clk),
    .RST_N(rst_n),
    .REG_ADDR(reg_addr),
    .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata),
    .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata),
    .IN_CLK_PRESENT(in_clk_present),
    .FREQ_ERR(freq_err),
    .FREQ_ERR_VALID(freq_err_valid),
    .DIV2_INT_HI(div2_int_hi),
    .DIV2_FORCE_INT(div2_force_int),
    .DIV2_FRAC_NUM(div2_frac_num),
    .DIV2_FRAC_DEN(div2_frac_den),
    .OUT_EN(out_en),
    .WAKE_DONE(wake_done),
    .LOCK_LOSS(lock_loss)
  );

  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Tasks are entered just after a falling edge and leave on one.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("reg_rdata", {24'h0, exp}, {24'h0, reg_rdata});
  endtask

  task automatic samp(logic [15:0] err);
    freq_err = err;
    freq_err_valid = 1'b1;
    @(negedge core_clk);
    freq_err_valid = 1'b0;
    @(negedge core_clk);
  endtask

  // Counts cycles until the indicator drops; a hang ends the run.
  task automatic wait_rel(output int cnt);
    cnt = 0;
    while (lock_loss !== 1'b0 && cnt < 3000)
    begin
      @(negedge core_clk);
      cnt++;
    end
    if (cnt >= 3000)
    begin
      chk("release_wait", 32'h0, {31'h0, lock_loss});
      finish_test();
    end
  endtask

  initial
  begin
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    wr(8'h29, 8'h20);
    repeat (40) @(negedge core_clk);
    chk("wake_wait", 32'h0, {31'h0, wake_done});
    chk("lock_loss", 32'h1, {31'h0, lock_loss});
    in_clk_present = 1'b1;
    repeat (5) @(negedge core_clk);
    chk("wake_done", 32'h1, {31'h0, wake_done});
    wr(8'h29, 8'h00);
    for (int a = 8'h1F; a <= 8'h2A; a++) rd(8'(a), 8'h00);
    wr(8'h1F, 8'hFF);
    chk("force_int", 32'h1, {31'h0, div2_force_int});
    chk("int_hi", 32'h1F, {27'h0, div2_int_hi});
    rd(8'h1F, 8'h3F);
    wr(8'h1F, 8'h0A);
    chk("force_int", 32'h0, {31'h0, div2_force_int});
    chk("int_hi", 32'h0A, {27'h0, div2_int_hi});
    for (int i = 0; i < 8; i++) wr(8'(8'h20 + i), 8'(8'hA0 + i));
    chk("frac_num", 32'hA3A2A1A0, div2_frac_num);
    chk("frac_den", 32'hA7A6A5A4, div2_frac_den);
    for (int i = 0; i < 8; i++) rd(8'(8'h20 + i), 8'(8'hA0 + i));
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h28, 8'(1 << i));
      chk("out_en", 32'(1 << i), {26'h0, out_en});
    end
    wr(8'h1E, 8'h55);
    rd(8'h1E, 8'h00);
    rd(8'h2B, 8'h00);
    wr(8'h2A, 8'h90);
    for (int d = 0; d < 4; d++)
    begin
      wr(8'h29, 8'(d << 1));
      samp(16'hFFFF);
      chk("ll_set", 32'h1, {31'h0, lock_loss});
      samp(16'h0000);
      wait_rel(n);
      chk("ll_not_early", 1, n >= (2 ** (BASE - 2 * d) - 1) * 25 - 3);
      chk("ll_not_late", 1, n <= 2 ** (BASE - 2 * d) * 25 + 5);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h29, 8'(8'h06 | (c >> 1)));
      wr(8'h2A, 8'(8'h90 | (c & 1)));
      samp(16'hFFFF);
      samp(clr_thr[c]);
      repeat (40) @(negedge core_clk);
      chk("ll_clr_hold", 32'h1, {31'h0, lock_loss});
      samp(clr_thr[c] - 16'h0001);
      wait_rel(n);
      chk("ll_clr_rel", 1, n <= 35);
    end
    for (int s = 0; s < 16; s++)
    begin
      wr(8'h2A, 8'(s << 4));
      samp(16'h0000);
      wait_rel(n);
      samp(set_thr[s < 10 ? s : 0]);
      chk("ll_at_set", 32'h0, {31'h0, lock_loss});
      samp(set_thr[s < 10 ? s : 0] + 16'h0001);
      chk("ll_above_set", 32'h1, {31'h0, lock_loss});
    end
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk("wake_start", 32'h0, {31'h0, wake_done});
    rd(8'h28, 8'h00);
    rd(8'h20, 8'h00);
    chk("lock_loss", 32'h1, {31'h0, lock_loss});
    repeat (25) @(negedge core_clk);
    chk("wake_nowait", 32'h1, {31'h0, wake_done});
    finish_test();
  end
endmodule
